// >>> pkg/sptc_pkg.sv
// ****************************************************************
// register map, field positions and encodings
// ****************************************************************
package sptc_pkg;
	// register offsets
	localparam logic [7:0] TXCS_ADDR = 8'h98; // transmit_control_status
	localparam logic [7:0] RXCS_ADDR = 8'h18; // receive_control_status
	localparam logic [7:0] TXDATA_ADDR = 8'h19; // transmit holding data
	localparam logic [7:0] TXSTAT_ADDR = 8'h1A; // transmit buffer status
	localparam logic [7:0] PBDIR_ADDR = 8'h86; // port_b_direction

	// transmit_control_status fields
	localparam int CLK_SRC_BIT = 7;
	localparam int NINE_SEL_BIT = 6;
	localparam int TX_ENABLE_BIT = 5;
	localparam int SYNC_BIT = 4;
	localparam int HIGH_BAUD_BIT = 2;
	localparam int SHIFT_EMPTY_BIT = 1;
	localparam int NINTH_DATA_BIT = 0;
	localparam logic [7:0] TXCS_WMASK = 8'hF5;
	localparam logic [7:0] TXCS_RESET = 8'h00;

	// receive_control_status fields
	localparam int PORT_ENABLE_BIT = 7;
	localparam int SINGLE_RX_BIT = 5;
	localparam int CONT_RX_BIT = 4;
	localparam logic [7:0] RXCS_WMASK = 8'hB0;
	localparam logic [7:0] RXCS_RESET = 8'h00;

	// port_b_direction fields
	localparam int DIR_CK_BIT = 2;
	localparam int DIR_DT_BIT = 1;
	localparam logic [7:0] PBDIR_RESET = 8'hFF;

	// transmit buffer status fields
	localparam int HOLD_EMPTY_BIT = 0;
	localparam int DT_LEVEL_BIT = 1;

	// frame sizes, as last data bit index
	localparam logic [3:0] LAST_BIT_8 = 4'h7;
	localparam logic [3:0] LAST_BIT_9 = 4'h8;

	// shift engine states
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_START = 4'b0010,
		ST_DATA = 4'b0100,
		ST_STOP = 4'b1000
	} sptc_state_e;
endpackage

// >>> src/sptc_sync2.sv
`timescale 1ns/10ps
// ****************************************************************
// two flip-flop synchroniser for pin levels
// ****************************************************************
module sptc_sync2 #(
	parameter int WIDTH = 2
) (
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// levels
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	// first stage is read by the second stage only
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= asyncIn;
			sync_ff <= meta_ff;
		end
	end

	assign syncOut = sync_ff;
endmodule

// >>> src/sptc_tick_gen.sv
`timescale 1ns/10ps
// ****************************************************************
// bit rate tick generator with two divisors
// ****************************************************************
module sptc_tick_gen #(
	parameter int DIV_W = 8,
	parameter logic [DIV_W-1:0] LOW_DIV = 8'h40,
	parameter logic [DIV_W-1:0] HIGH_DIV = 8'h10
) (
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// control
	input wire logic run,
	input wire logic selHigh,
	// output pulse
	output logic tick
);
	logic [DIV_W-1:0] count_ff;
	logic [DIV_W-1:0] nxt_count;
	wire logic [DIV_W-1:0] lastCount = (selHigh ? HIGH_DIV : LOW_DIV) - 1'b1;
	wire logic wrap = (count_ff >= lastCount);

	// counter restarts whenever run drops so each frame starts a full period
	assign nxt_count = !run ? '0 : (wrap ? '0 : count_ff + 1'b1);
	assign tick = run && wrap;

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			count_ff <= '0;
		end else begin
			count_ff <= nxt_count;
		end
	end
endmodule

// >>> src/sptc_transmit_control.sv
// Our own choice: the address-and-strobe port.
`timescale 1ns/10ps
module sptc_transmit_control #(
	parameter int DIV_W = 8,
	parameter logic [DIV_W-1:0] LOW_DIV = 8'h40,
	parameter logic [DIV_W-1:0] HIGH_DIV = 8'h10
) (
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// register port
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regRdData,
	// transmit_clock_pin
	input wire logic transmitClockPinIn,
	output logic transmitClockPinOut,
	output logic transmitClockPinOutEn_n,
	// receive_data_pin
	input wire logic receiveDataPinIn,
	output logic receiveDataPinOut,
	output logic receiveDataPinOutEn_n
);
	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic logic hitReg(input logic [7:0] addr, input logic [7:0] target);
		return addr == target;
	endfunction

	function automatic logic [7:0] maskWrite(input logic [7:0] old, input logic [7:0] data,
			input logic [7:0] mask);
		return (old & ~mask) | (data & mask);
	endfunction

	// ****************************************************************
	// state
	// ****************************************************************
	logic [7:0] txCtrl_ff;
	logic [7:0] rxCtrl_ff;
	logic [7:0] portDir_ff;
	logic [7:0] holdData_ff;
	logic holdFull_ff;
	logic [8:0] shift_ff;
	logic [3:0] bitCnt_ff;
	sptc_pkg::sptc_state_e state_ff;
	logic sclk_ff;
	logic extCkPrev_ff;
	logic [7:0] rdData_ff;
	logic ckOut_ff;
	logic ckOutEn_n_ff;
	logic dtOut_ff;
	logic dtOutEn_n_ff;

	logic [7:0] nxt_txCtrl;
	logic [7:0] nxt_rxCtrl;
	logic [7:0] nxt_portDir;
	logic [7:0] nxt_holdData;
	logic nxt_holdFull;
	logic [8:0] nxt_shift;
	logic [3:0] nxt_bitCnt;
	sptc_pkg::sptc_state_e nxt_state;
	logic nxt_sclk;
	logic [7:0] nxt_rdData;

	// ****************************************************************
	// register decode
	// ****************************************************************
	wire logic wrTxCtrl = regWrite && hitReg(regAddr, sptc_pkg::TXCS_ADDR);
	wire logic wrRxCtrl = regWrite && hitReg(regAddr, sptc_pkg::RXCS_ADDR);
	wire logic wrPortDir = regWrite && hitReg(regAddr, sptc_pkg::PBDIR_ADDR);
	wire logic wrHold = regWrite && hitReg(regAddr, sptc_pkg::TXDATA_ADDR);

	// control fields
	wire logic clockSource = txCtrl_ff[sptc_pkg::CLK_SRC_BIT];
	wire logic nineBitSel = txCtrl_ff[sptc_pkg::NINE_SEL_BIT];
	wire logic txEnableBit = txCtrl_ff[sptc_pkg::TX_ENABLE_BIT];
	wire logic syncMode = txCtrl_ff[sptc_pkg::SYNC_BIT];
	wire logic highBaud = txCtrl_ff[sptc_pkg::HIGH_BAUD_BIT];
	wire logic ninthBit = txCtrl_ff[sptc_pkg::NINTH_DATA_BIT];
	wire logic portEnable = rxCtrl_ff[sptc_pkg::PORT_ENABLE_BIT];
	wire logic singleRx = rxCtrl_ff[sptc_pkg::SINGLE_RX_BIT];
	wire logic contRx = rxCtrl_ff[sptc_pkg::CONT_RX_BIT];

	// ****************************************************************
	// mode decode
	// ****************************************************************
	// both pins belong to the port only with enable and both direction bits
	wire logic pinsOwned = portEnable && portDir_ff[sptc_pkg::DIR_CK_BIT]
		&& portDir_ff[sptc_pkg::DIR_DT_BIT];
	// half duplex: a receive request in sync mode takes the data line
	wire logic rxOverride = syncMode && (singleRx || contRx);
	wire logic txEnabled = txEnableBit && pinsOwned && !rxOverride;
	// clock select only matters once sync mode is chosen
	wire logic syncMaster = syncMode && clockSource;
	wire logic syncSlave = syncMode && !clockSource;
	wire logic asyncMode = !syncMode;
	wire logic idle = (state_ff == sptc_pkg::ST_IDLE);
	wire logic shiftEmpty = idle;
	wire logic [3:0] lastBit = nineBitSel ? sptc_pkg::LAST_BIT_9 : sptc_pkg::LAST_BIT_8;
	wire logic loadShift = txEnabled && holdFull_ff && idle;

	// ****************************************************************
	// pin sampling and bit timing
	// ****************************************************************
	logic [1:0] pinSync;
	logic tick;

	sptc_sync2 #(
		.WIDTH(2)
	) u_pinSync (
		.clock(clock),
		.reset_n(reset_n),
		.asyncIn({transmitClockPinIn, receiveDataPinIn}),
		.syncOut(pinSync)
	);

	wire logic ckSync = pinSync[1];
	wire logic dtSync = pinSync[0];
	// slave shifts on the falling edge of the external clock
	wire logic extCkFall = extCkPrev_ff && !ckSync;

	// sync master always runs at the fast divisor as half period
	wire logic selHigh = syncMode ? 1'b1 : highBaud;

	sptc_tick_gen #(
		.DIV_W(DIV_W),
		.LOW_DIV(LOW_DIV),
		.HIGH_DIV(HIGH_DIV)
	) u_tickGen (
		.clock(clock),
		.reset_n(reset_n),
		.run(txEnabled && !idle),
		.selHigh(selHigh),
		.tick(tick)
	);

	// one step per bit: async tick, master falling clock, slave external fall
	wire logic step = asyncMode ? tick : (syncMaster ? (tick && sclk_ff) : extCkFall);

	// ****************************************************************
	// register writes
	// ****************************************************************
	// read-only flag and unused bit are outside the write mask
	assign nxt_txCtrl = wrTxCtrl ? maskWrite(txCtrl_ff, regWrData, sptc_pkg::TXCS_WMASK)
		: txCtrl_ff;
	assign nxt_rxCtrl = wrRxCtrl ? maskWrite(rxCtrl_ff, regWrData, sptc_pkg::RXCS_WMASK) : rxCtrl_ff;
	assign nxt_portDir = wrPortDir ? regWrData : portDir_ff;
	assign nxt_holdData = wrHold ? regWrData : holdData_ff;
	// a write in the cycle the holding word moves on keeps the new word
	assign nxt_holdFull = wrHold ? 1'b1 : (loadShift ? 1'b0 : holdFull_ff);

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			txCtrl_ff <= sptc_pkg::TXCS_RESET;
			rxCtrl_ff <= sptc_pkg::RXCS_RESET;
			portDir_ff <= sptc_pkg::PBDIR_RESET;
			holdData_ff <= 8'h00;
			holdFull_ff <= 1'b0;
		end else begin
			txCtrl_ff <= nxt_txCtrl;
			rxCtrl_ff <= nxt_rxCtrl;
			portDir_ff <= nxt_portDir;
			holdData_ff <= nxt_holdData;
			holdFull_ff <= nxt_holdFull;
		end
	end

	// ****************************************************************
	// shift engine
	// ****************************************************************
	// dropping the enable aborts the frame so the shifter reads empty at once
	always_comb begin
		nxt_state = state_ff;
		nxt_shift = shift_ff;
		nxt_bitCnt = bitCnt_ff;
		if (!txEnabled) begin
			nxt_state = sptc_pkg::ST_IDLE;
		end else begin
			case (state_ff)
				sptc_pkg::ST_IDLE: begin
					if (loadShift) begin
						nxt_shift = {ninthBit, holdData_ff};
						nxt_bitCnt = 4'h0;
						nxt_state = asyncMode ? sptc_pkg::ST_START : sptc_pkg::ST_DATA;
					end
				end
				sptc_pkg::ST_START: begin
					if (step) begin
						nxt_state = sptc_pkg::ST_DATA;
					end
				end
				sptc_pkg::ST_DATA: begin
					if (step) begin
						nxt_shift = {1'b0, shift_ff[8:1]};
						nxt_bitCnt = bitCnt_ff + 4'h1;
						if (bitCnt_ff == lastBit) begin
							nxt_state = asyncMode ? sptc_pkg::ST_STOP : sptc_pkg::ST_IDLE;
						end
					end
				end
				sptc_pkg::ST_STOP: begin
					if (step) begin
						nxt_state = sptc_pkg::ST_IDLE;
					end
				end
				default: begin
					nxt_state = sptc_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// master clock idles low and toggles each tick while a frame runs
	assign nxt_sclk = (syncMaster && txEnabled && !idle) ? (tick ? !sclk_ff : sclk_ff) : 1'b0;

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			state_ff <= sptc_pkg::ST_IDLE;
			shift_ff <= 9'h000;
			bitCnt_ff <= 4'h0;
			sclk_ff <= 1'b0;
			extCkPrev_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			shift_ff <= nxt_shift;
			bitCnt_ff <= nxt_bitCnt;
			sclk_ff <= nxt_sclk;
			extCkPrev_ff <= ckSync;
		end
	end

	// ****************************************************************
	// pin drive
	// ****************************************************************
	// async line idles high, start low, stop high; sync line shows bit 0
	wire logic lineVal = (state_ff == sptc_pkg::ST_START) ? 1'b0
		: ((state_ff == sptc_pkg::ST_DATA) ? shift_ff[0] : asyncMode);
	// async: clock pin carries data; master: clock pin carries clock
	wire logic nxt_ckOut = asyncMode ? lineVal : sclk_ff;
	wire logic nxt_ckOutEn_n = !(pinsOwned && !syncSlave);
	// data pin driven only during a sync frame, released for reception
	wire logic nxt_dtOut = syncMode && lineVal;
	wire logic nxt_dtOutEn_n = !(syncMode && txEnabled && !idle);

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			ckOut_ff <= 1'b1;
			ckOutEn_n_ff <= 1'b1;
			dtOut_ff <= 1'b0;
			dtOutEn_n_ff <= 1'b1;
		end else begin
			ckOut_ff <= nxt_ckOut;
			ckOutEn_n_ff <= nxt_ckOutEn_n;
			dtOut_ff <= nxt_dtOut;
			dtOutEn_n_ff <= nxt_dtOutEn_n;
		end
	end

	assign transmitClockPinOut = ckOut_ff;
	assign transmitClockPinOutEn_n = ckOutEn_n_ff;
	assign receiveDataPinOut = dtOut_ff;
	assign receiveDataPinOutEn_n = dtOutEn_n_ff;

	// ****************************************************************
	// read path
	// ****************************************************************
	// unused bit always zero, shift flag is live state
	wire logic [7:0] txCtrlView = {txCtrl_ff[7:4], 1'b0, highBaud, shiftEmpty, ninthBit};
	wire logic [7:0] txStatView = {6'h00, dtSync, !holdFull_ff};
	wire logic [7:0] readMux =
		hitReg(regAddr, sptc_pkg::TXCS_ADDR) ? txCtrlView :
		hitReg(regAddr, sptc_pkg::RXCS_ADDR) ? rxCtrl_ff :
		hitReg(regAddr, sptc_pkg::PBDIR_ADDR) ? portDir_ff :
		hitReg(regAddr, sptc_pkg::TXDATA_ADDR) ? holdData_ff :
		hitReg(regAddr, sptc_pkg::TXSTAT_ADDR) ? txStatView : 8'h00;

	// data stand only in the cycle after the strobe, zero otherwise
	assign nxt_rdData = regRead ? readMux : 8'h00;

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			rdData_ff <= 8'h00;
		end else begin
			rdData_ff <= nxt_rdData;
		end
	end

	assign regRdData = rdData_ff;
endmodule

// >>> test/sptc_serial_peer.sv
`timescale 1ns/10ps
// ****
// serial peer on the far side of the pins
// ****
module sptc_serial_peer (
	// clock
	input wire logic clock,
	// resolved pin levels
	input wire logic ckWire,
	input wire logic dtWire,
	// settings
	input wire logic syncMode,
	input wire logic slaveClk,
	input wire logic [31:0] bitCycles,
	input wire logic [31:0] nBits,
	// drive and capture
	output logic extClk,
	output logic peerData,
	output logic [8:0] word,
	output int frames
);
	initial begin
		extClk = 1'b0;
		peerData = 1'b0;
		word = 9'h000;
		frames = 0;
	end
	// released data line toggles so a stale level never reads as data
	always @(posedge clock) peerData <= ~peerData;
	// slave clock runs only inside frames, 80 ns period
	// offset from the system clock edge so the synchroniser never races it
	always begin
		@(posedge slaveClk);
		#2;
		while (slaveClk) begin
			#40 extClk = 1'b1;
			#40 extClk = 1'b0;
		end
	end
	// async: bit centres, lsb first, counted only with a high stop bit
	always @(negedge ckWire) begin
		if (!syncMode) begin
			word = 9'h000;
			repeat (bitCycles / 2) @(posedge clock);
			for (int i = 0; i < nBits; i++) begin
				repeat (bitCycles) @(posedge clock);
				word[i] = ckWire;
			end
			repeat (bitCycles) @(posedge clock);
			if (ckWire) frames++;
		end
	end
	// sync: one bit per rising clock, lsb first
	always @(posedge ckWire) begin
		if (syncMode) begin
			word = {1'b0, dtWire, word[7:1]};
			frames++;
		end
	end
endmodule

// >>> test/sptc_transmit_control_assertions.sv
`timescale 1ns/10ps
// ****
// port checker for the transmit control block
// ****
module sptc_transmit_control_assertions (
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// register port
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regRdData,
	// pins
	input wire logic transmitClockPinIn,
	input wire logic transmitClockPinOut,
	input wire logic transmitClockPinOutEn_n,
	input wire logic receiveDataPinIn,
	input wire logic receiveDataPinOut,
	input wire logic receiveDataPinOutEn_n
);
	logic [7:0] txShadow_ff, rxShadow_ff, dirShadow_ff;
	logic [1:0] age_ff;
	logic txHit, rxHit, dirHit, owned, sync, steady, txRead, txOff;
	// decode; steady waits out the register and pin pipeline after a change
	assign txHit = regWrite && regAddr == sptc_pkg::TXCS_ADDR;
	assign rxHit = regWrite && regAddr == sptc_pkg::RXCS_ADDR;
	assign dirHit = regWrite && regAddr == sptc_pkg::PBDIR_ADDR;
	assign owned = rxShadow_ff[7] && dirShadow_ff[2] && dirShadow_ff[1];
	assign sync = txShadow_ff[4];
	assign steady = age_ff == 2'h3;
	assign txRead = regRead && regAddr == sptc_pkg::TXCS_ADDR;
	assign txOff = steady && !txShadow_ff[5];
	// shadows mirror the control registers
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			txShadow_ff <= 8'h00;
			rxShadow_ff <= 8'h00;
			dirShadow_ff <= 8'hFF;
		end else begin
			if (txHit) txShadow_ff <= regWrData & sptc_pkg::TXCS_WMASK;
			if (rxHit) rxShadow_ff <= regWrData & sptc_pkg::RXCS_WMASK;
			if (dirHit) dirShadow_ff <= regWrData;
		end
	end
	// cycles since the last configuration change, saturating
	always_ff @(posedge clock) begin
		if (!reset_n || txHit || rxHit || dirHit) age_ff <= 2'h0;
		else if (age_ff != 2'h3) age_ff <= age_ff + 2'h1;
	end
	default clocking @(posedge clock);
	endclocking
	default disable iff (!reset_n);
	// pin ownership and mode selection
	a_pins_released: assert property (steady && !owned |-> transmitClockPinOutEn_n && receiveDataPinOutEn_n)
		else $error("pin driven while port not owned");
	a_async_pins: assert property (steady && owned && !sync |-> !transmitClockPinOutEn_n && receiveDataPinOutEn_n)
		else $error("async pin directions wrong");
	a_slave_clock_in: assert property (steady && owned && sync && !txShadow_ff[7] |-> transmitClockPinOutEn_n)
		else $error("slave drives the clock");
	a_master_clock_out: assert property (steady && owned && sync && txShadow_ff[7] |-> !transmitClockPinOutEn_n)
		else $error("master does not drive the clock");
	a_rx_overrides_tx: assert property (steady && sync && rxShadow_ff[5:4] != 2'b00 |-> receiveDataPinOutEn_n)
		else $error("data driven while receiving");
	a_sync_tx_off: assert property (txOff && sync |-> receiveDataPinOutEn_n)
		else $error("data driven with transmit off");
	a_idle_line_high: assert property (txOff && owned && !sync |-> transmitClockPinOut)
		else $error("async line not idle high");
	// control register reads
	a_tx_readback: assert property ($past(txRead) |-> (regRdData & 8'hF5) == ($past(txShadow_ff) & 8'hF5))
		else $error("control readback differs");
	a_reserved_zero: assert property ($past(txRead) |-> !regRdData[3])
		else $error("unused bit reads one");
	a_empty_when_off: assert property ($past(txRead) && $past(txOff) |-> regRdData[1])
		else $error("shift flag full with transmit off");
endmodule

bind sptc_transmit_control sptc_transmit_control_assertions chk (.clock(clock), .reset_n(reset_n),
	.regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
	.transmitClockPinIn(transmitClockPinIn), .transmitClockPinOut(transmitClockPinOut),
	.transmitClockPinOutEn_n(transmitClockPinOutEn_n), .receiveDataPinIn(receiveDataPinIn),
	.receiveDataPinOut(receiveDataPinOut), .receiveDataPinOutEn_n(receiveDataPinOutEn_n));

// >>> test/sptc_transmit_control_tb.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin \
	numChecks++; \
	if ((g) !== (e)) begin \
		failures++; \
		$display("unexpected %s expected %h seen %h", n, e, g); \
	end \
end
// ****
// testbench
// ****
module sptc_transmit_control_tb;
	logic clock, reset_n, regWrite, regRead, ckOut, ckEn_n, dtOut, dtEn_n;
	logic ckWire, dtWire, extClk, peerData, syncMode, slaveClk;
	logic [7:0] regAddr, regWrData, regRdData;
	logic [8:0] word;
	int bitCycles, nBits, frames, failures, numChecks;
	// pin levels from all drivers
	assign ckWire = ckEn_n ? extClk : ckOut;
	assign dtWire = dtEn_n ? peerData : dtOut;
	// short divisors keep frames brief
	sptc_transmit_control #(.DIV_W(8), .LOW_DIV(8'h08), .HIGH_DIV(8'h04)) dut (.clock(clock), .reset_n(reset_n),
		.regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
		.transmitClockPinIn(ckWire), .transmitClockPinOut(ckOut), .transmitClockPinOutEn_n(ckEn_n),
		.receiveDataPinIn(dtWire), .receiveDataPinOut(dtOut), .receiveDataPinOutEn_n(dtEn_n));
	sptc_serial_peer peer (.clock(clock), .ckWire(ckWire), .dtWire(dtWire), .syncMode(syncMode),
		.slaveClk(slaveClk), .bitCycles(bitCycles), .nBits(nBits), .extClk(extClk), .peerData(peerData),
		.word(word), .frames(frames));
	always #5 clock = ~clock;
	// register port; the idle cycle after a write avoids a double drive
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge clock);
		regWrite <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clock);
		regRead <= 1'b0;
		#1 v = regRdData;
		@(posedge clock);
	endtask
	task automatic waitFrames(input int n);
		for (int i = 0; i < 600 && frames < n; i++) @(posedge clock);
		`CHK("frames seen", n, frames)
	endtask
	task automatic t_regs();
		logic [7:0] v;
		rd(sptc_pkg::TXCS_ADDR, v);
		`CHK("control reset", 8'h02, v)
		wr(sptc_pkg::TXCS_ADDR, 8'hFF);
		rd(sptc_pkg::TXCS_ADDR, v);
		`CHK("control readback", 8'hF7, v)
		wr(sptc_pkg::TXCS_ADDR, 8'h10);
		rd(sptc_pkg::PBDIR_ADDR, v);
		`CHK("direction reset", 8'hFF, v)
		rd(8'h55, v);
		`CHK("unmapped read", 8'h00, v)
		wr(sptc_pkg::RXCS_ADDR, 8'h80);
	endtask
	task automatic t_async(input logic nine, input logic ninth, input logic high, input logic [7:0] d);
		logic [7:0] v;
		int f;
		syncMode = 1'b0;
		f = frames;
		bitCycles = high ? 4 : 8;
		nBits = nine ? 9 : 8;
		wr(sptc_pkg::TXCS_ADDR, {1'b0, nine, 3'b100, high, 1'b0, ninth});
		wr(sptc_pkg::TXDATA_ADDR, d);
		rd(sptc_pkg::TXCS_ADDR, v);
		`CHK("shift flag busy", 1'b0, v[1])
		waitFrames(f + 1);
		`CHK("async word", {nine & ninth, d}, word)
		repeat (bitCycles) @(posedge clock);
		rd(sptc_pkg::TXCS_ADDR, v);
		`CHK("shift flag idle", 1'b1, v[1])
	endtask
	task automatic t_sync(input logic [7:0] ctl, input logic [7:0] d);
		int f;
		syncMode = 1'b1;
		f = frames;
		wr(sptc_pkg::TXCS_ADDR, ctl);
		wr(sptc_pkg::TXDATA_ADDR, d);
		`CHK("clock direction", ~ctl[7], ckEn_n)
		slaveClk = ~ctl[7];
		waitFrames(f + 8);
		slaveClk = 1'b0;
		`CHK("sync byte", d, word[7:0])
	endtask
	task automatic t_override();
		logic [7:0] v;
		int f;
		wr(sptc_pkg::TXCS_ADDR, 8'hB0);
		wr(sptc_pkg::RXCS_ADDR, 8'h90);
		wr(sptc_pkg::TXDATA_ADDR, 8'h11);
		repeat (40) @(posedge clock);
		`CHK("data released", 1'b1, dtEn_n)
		rd(sptc_pkg::TXCS_ADDR, v);
		`CHK("no frame held", 1'b1, v[1])
		rd(sptc_pkg::TXSTAT_ADDR, v);
		`CHK("holding word kept", 1'b0, v[0])
		f = frames;
		wr(sptc_pkg::RXCS_ADDR, 8'h80);
		waitFrames(f + 8);
		`CHK("held word sent", 8'h11, word[7:0])
	endtask
	task automatic t_pins_abort();
		logic [7:0] v;
		wr(sptc_pkg::PBDIR_ADDR, 8'hF9);
		repeat (4) @(posedge clock);
		`CHK("pins released", 2'b11, {ckEn_n, dtEn_n})
		wr(sptc_pkg::PBDIR_ADDR, 8'hFF);
		syncMode = 1'b0;
		wr(sptc_pkg::TXCS_ADDR, 8'h24);
		wr(sptc_pkg::TXDATA_ADDR, 8'hF0);
		repeat (10) @(posedge clock);
		wr(sptc_pkg::TXCS_ADDR, 8'h04);
		repeat (4) @(posedge clock);
		`CHK("line idle after abort", 1'b1, ckOut)
		rd(sptc_pkg::TXCS_ADDR, v);
		`CHK("shift flag after abort", 1'b1, v[1])
	endtask
	task automatic print_verdict();
		$display("checks %0d failures %0d", numChecks, failures);
		if (failures == 0 && numChecks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// main sequence; peer starts in sync so reset noise is not taken as a frame
	initial begin
		{clock, reset_n, regWrite, regRead, slaveClk} = 5'h00;
		{regAddr, regWrData} = 16'h0000;
		syncMode = 1'b1;
		{bitCycles, nBits, failures, numChecks} = {32'd8, 32'd8, 32'd0, 32'd0};
		repeat (12) @(posedge clock);
		reset_n <= 1'b1;
		@(posedge clock);
		t_regs();
		t_async(1'b0, 1'b0, 1'b1, 8'hA5);
		t_async(1'b1, 1'b1, 1'b1, 8'h3C);
		t_async(1'b1, 1'b0, 1'b0, 8'hC3);
		t_async(1'b0, 1'b1, 1'b0, 8'h5A);
		t_sync(8'hB0, 8'h96);
		t_sync(8'h30, 8'h4B);
		t_override();
		t_pins_abort();
		print_verdict();
	end
	// watchdog: the run needs well under 3000 cycles
	initial begin
		repeat (6000) @(posedge clock);
		failures++;
		print_verdict();
	end
endmodule
